// file: pwm_far_side.sv
// far side model: external sync sources and generator event sources
module pwm_far_side #(
	parameter int NGEN = 2
) (
	input wire logic clk,
	input wire logic idle_high,
	output logic sync_input_one,
	output logic sync_input_two,
	output logic [1:0] pattern_trigger_unit,
	output logic [NGEN-1:0] fault_event,
	output logic [NGEN-1:0] current_limit_event,
	output logic [NGEN-1:0] trigger_event
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] act = 4'h0;
	logic [NGEN-1:0] ev = '0;

	// ==========================================================
	// lines
	// idle at the inactive level of the chosen polarity
	assign {pattern_trigger_unit, sync_input_two, sync_input_one} =
		{4{idle_high}} ^ act;
	assign fault_event = ev;
	assign current_limit_event = ev;
	assign trigger_event = ev;

	// ==========================================================
	// pulses
	// codes above 3 pulse every source, so a reserved code sees activity
	task automatic pulse_sync(input int code);
		@(posedge clk);
		act <= (code > 3) ? 4'hf : 4'h1 << code;
		@(posedge clk);
		act <= 4'h0;
	endtask

	task automatic pulse_gen(input int idx);
		@(posedge clk);
		ev[idx] <= 1'b1;
		@(posedge clk);
		ev <= '0;
	endtask
endmodule

// file: pwm_postscaler.sv
// match postscaler: one fire pulse per (ratio + 1) matches
module pwm_postscaler #(
	parameter int W = 4
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic run,
	input wire logic match,
	input wire logic [W-1:0] ratio,
	output logic fire
);
	import pwm_regs_pkg::*;

	typedef struct packed {
		logic [W-1:0] cnt;
		logic fire;
	} post_t;

	post_t s;
	post_t n;

	always_comb begin
		n = s;
		n.fire = 1'b0;
		if (!run) begin
			n.cnt = '0;
		end else if (match) begin
			if (s.cnt >= ratio) begin
				n.cnt = '0;
				n.fire = 1'b1;
			end else begin
				n.cnt = s.cnt + W'(1);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign fire = s.fire;

	post_fire_a: assert property (@(posedge clk) disable iff (!rst_b)
		fire |-> $past(match) && $past(s.cnt) >= $past(ratio))
		else $error("postscaler fired early");
endmodule

// file: pwm_prescaler.sv
// input clock prescaler: one-cycle tick every 2**code clocks, 64 clocks for both codes 6 and 7
module pwm_prescaler (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic run,
	input wire logic [2:0] code,
	output logic tick
);
	import pwm_regs_pkg::*;

	typedef struct packed {
		logic [5:0] cnt;
		logic tick;
	} pre_t;

	pre_t s;
	pre_t n;
	logic [5:0] limit;

	always_comb begin
		n = s;
		n.tick = 1'b0;
		// reserved code behaves as the largest divide
		limit = (code >= DIV_MAX) ? 6'h3f : 6'((7'h01 << code) - 7'h01);
		if (!run) begin
			n.cnt = 6'h00;
		end else if (s.cnt >= limit) begin
			n.cnt = 6'h00;
			n.tick = 1'b1;
		end else begin
			n.cnt = s.cnt + 6'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign tick = s.tick;

	div_one_a: assert property (@(posedge clk) disable iff (!rst_b)
		run && code == 3'h0 |=> tick) else $error("divide-by-1 missed tick");
	div_gap_a: assert property (@(posedge clk) disable iff (!rst_b)
		tick && code != 3'h0 && $stable(code) |=> !tick)
		else $error("prescaler ticked twice");
endmodule

// file: pwm_regs_pkg.sv
// register map, field positions and constants of the pwm time base block
package pwm_regs_pkg;

	// ==========================================================
	// bus and register offsets (byte addresses)
	localparam int ADDR_W = 8;
	localparam logic [7:0] A_PRI_CTL = 8'h00;
	localparam logic [7:0] A_PRI_DIV = 8'h04;
	localparam logic [7:0] A_PRI_PER = 8'h08;
	localparam logic [7:0] A_PRI_CMP = 8'h0c;
	localparam logic [7:0] A_SEC_CTL = 8'h10;
	localparam logic [7:0] A_SEC_DIV = 8'h14;
	localparam logic [7:0] A_SEC_PER = 8'h18;
	localparam logic [7:0] A_SEC_CMP = 8'h1c;
	localparam logic [7:0] A_CHOP = 8'h20;
	localparam logic [7:0] A_DUTY = 8'h24;
	localparam logic [7:0] A_KEY = 8'h28;
	localparam logic [7:0] A_OUT_CTL = 8'h2c;
	localparam logic [7:0] A_FLT_CTL = 8'h30;
	localparam logic [7:0] A_GEN = 8'h40;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==========================================================
	// field positions
	localparam int B_MOD_EN = 15;
	localparam int B_EPEND = 12;
	localparam int B_EIE = 11;
	localparam int B_IMM = 10;
	localparam int B_INV = 9;
	localparam int B_SOE = 8;
	localparam int B_XSYNC = 7;
	localparam int SRC_LSB = 4;
	localparam int PS_LSB = 0;
	localparam int CMP_LSB = 3;
	localparam int CHOP_EN = 15;
	localparam int CHOP_LSB = 3;
	localparam int GEN_LSB = 8;

	// ==========================================================
	// reset values, keys, codes
	localparam logic [15:0] PERIOD_RST = 16'hffff;
	localparam logic [15:0] KEY_ONE = 16'habcd;
	localparam logic [15:0] KEY_TWO = 16'h4321;
	localparam logic [15:0] DUTY_EDGE = 16'h0008;
	localparam logic [2:0] SRC_IN1 = 3'h0;
	localparam logic [2:0] SRC_IN2 = 3'h1;
	localparam logic [2:0] SRC_PTG16 = 3'h2;
	localparam logic [2:0] SRC_PTG17 = 3'h3;
	localparam logic [2:0] DIV_MAX = 3'h6;

	// ==========================================================
	// timing weights, in picoseconds at the fastest input clock
	localparam int LSB_PS = 1040;
	localparam int CMP_RES_PS = 8320;
	localparam int CHOP_UNIT_PS = 16640;
	localparam int CHOP_STEPS = CHOP_UNIT_PS / LSB_PS;

	typedef enum logic [1:0] {key_idle, key_half, key_open} key_t;

	typedef struct packed {
		logic fault_pending;
		logic current_limit_pending;
		logic trigger_pending;
		logic fault_irq_enable;
		logic current_limit_irq_enable;
		logic trigger_irq_enable;
		logic own_period_select;
		logic shared_duty_select;
	} gen_t;

endpackage

// file: pwm_time_base.sv
// pwm secondary time base, chopper, shared duty and generator control
// Function
// - secondary compare field bits 15:3, low zero
// - compare lsb 1.04 ns, step 8.32 ns
// - event sets pending; irq only when enabled
// - immediate or boundary-deferred period load
// - sync polarity bit inverts sync in/out
// - sync output driven only when enabled
// - external sync resets secondary time base
// - three-bit sync source select, upper reserved
// - trigger every postscale-plus-one compare matches
// - secondary prescaler divides by two power code; code 7 divides by 64 like code 6
// - secondary period sixteen bits, resets all ones
// - chop runs when enabled, 16.64(n+1) period
// - chop clocked by primary prescaler
// - shared duty clamped 0x0008 to period-0x0008
// - duty near edges may lose lsbs
// - fault/limit pending cleared by enable zero
// - trigger pending, irq gated by enable
// - own period select chooses period source
// - shared duty select chooses duty source
// - key 0xabcd then 0x4321 unlocks once
// - unlock lost on any intervening access
// - module enable turns block on
//
// Local design decisions: the register offsets and the AXI4-Lite register port.
module pwm_time_base #(
	parameter int NGEN = 8
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic awvalid,
	output logic awready,
	input wire logic [pwm_regs_pkg::ADDR_W-1:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [pwm_regs_pkg::ADDR_W-1:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	input wire logic sync_input_one,
	input wire logic sync_input_two,
	input wire logic [1:0] pattern_trigger_unit,
	input wire logic [NGEN-1:0] fault_event,
	input wire logic [NGEN-1:0] current_limit_event,
	input wire logic [NGEN-1:0] trigger_event,
	output logic secondary_sync_output,
	output logic secondary_sync_output_oe_b,
	output logic secondary_event_trigger,
	output logic secondary_event_irq,
	output logic [15:0] secondary_master_counter,
	output logic chop_clock,
	output logic [15:0] shared_duty,
	output logic [NGEN-1:0] generator_irq,
	output logic [NGEN-1:0] own_period_select,
	output logic [NGEN-1:0] shared_duty_select
);
	import pwm_regs_pkg::*;

	// ==========================================================
	// state
	typedef struct packed {
		logic module_enable;
		logic [2:0] pri_div;
		logic [15:0] pri_period;
		logic [12:0] pri_cmp;
		logic [12:0] sec_ctl;
		logic [2:0] sec_div;
		logic [15:0] sec_period;
		logic [15:0] sec_active;
		logic [15:0] sec_cnt;
		logic [12:0] sec_cmp;
		logic chop_en;
		logic [6:0] chop_div;
		logic [9:0] chop_cnt;
		logic chop_out;
		logic [15:0] duty;
		logic [15:0] duty_out;
		logic [15:0] out_ctl;
		logic [15:0] flt_ctl;
		key_t key;
		logic match;
		logic wrap;
		logic sync_prev;
		logic sync_out;
		logic sync_oe_b;
		logic irq;
		gen_t [NGEN-1:0] gen;
		logic [NGEN-1:0] gen_irq;
		logic aw_held;
		logic [ADDR_W-1:0] aw_addr;
		logic w_held;
		logic [15:0] wdata;
		logic [1:0] wstrb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} state_t;

	state_t s;
	state_t n;
	logic wr;
	logic rd;
	logic sel;
	logic raw_sync;
	logic sync_edge;
	logic sec_tick;
	logic pri_tick;
	logic fire;
	logic [16:0] old;
	logic [16:0] rv;
	logic [15:0] m;
	logic [15:0] wv;
	logic [15:0] hi;
	logic [9:0] chop_lim;

	// returns {hit, value}; unmapped reads miss
	function automatic logic [16:0] reg_read(input state_t st,
		input logic [ADDR_W-1:0] a);
		logic [16:0] r;
		r = {1'b1, 16'h0000};
		case (a)
			A_PRI_CTL: r[15:0] = {st.module_enable, 15'h0000};
			A_PRI_DIV: r[15:0] = {13'h0000, st.pri_div};
			A_PRI_PER: r[15:0] = st.pri_period;
			A_PRI_CMP: r[15:0] = {st.pri_cmp, 3'h0};
			A_SEC_CTL: r[15:0] = {3'h0, st.sec_ctl};
			A_SEC_DIV: r[15:0] = {13'h0000, st.sec_div};
			A_SEC_PER: r[15:0] = st.sec_period;
			A_SEC_CMP: r[15:0] = {st.sec_cmp, 3'h0};
			A_CHOP: r[15:0] = {st.chop_en, 5'h00, st.chop_div, 3'h0};
			A_DUTY: r[15:0] = st.duty;
			A_KEY: r[15:0] = 16'h0000;
			A_OUT_CTL: r[15:0] = st.out_ctl;
			A_FLT_CTL: r[15:0] = st.flt_ctl;
			default: begin
				r[16] = 1'b0;
				for (int i = 0; i < NGEN; i++) begin
					if (a == A_GEN + ADDR_W'(4 * i)) begin
						r = {1'b1, st.gen[i], 8'h00};
					end
				end
			end
		endcase
		return r;
	endfunction

	// ==========================================================
	// prescalers and postscaler
	pwm_prescaler u_pri_pre (
		.clk(clk),
		.rst_b(rst_b),
		.run(s.module_enable),
		.code(s.pri_div),
		.tick(pri_tick)
	);

	pwm_prescaler u_sec_pre (
		.clk(clk),
		.rst_b(rst_b),
		.run(s.module_enable),
		.code(s.sec_div),
		.tick(sec_tick)
	);

	pwm_postscaler #(.W(4)) u_post (
		.clk(clk),
		.rst_b(rst_b),
		.run(s.module_enable),
		.match(s.match),
		.ratio(s.sec_ctl[PS_LSB+:4]),
		.fire(fire)
	);

	// ==========================================================
	// next state
	always_comb begin
		n = s;
		n.match = 1'b0;
		n.wrap = 1'b0;
		wr = s.aw_held && s.w_held && !s.bvalid;
		rd = arvalid && s.arready;
		old = reg_read(s, s.aw_addr);
		rv = reg_read(s, araddr);
		m = {{8{s.wstrb[1]}}, {8{s.wstrb[0]}}};
		wv = (old[15:0] & ~m) | (s.wdata & m);
		case (s.sec_ctl[SRC_LSB+:3])
			SRC_IN1: sel = sync_input_one;
			SRC_IN2: sel = sync_input_two;
			SRC_PTG16: sel = pattern_trigger_unit[0];
			SRC_PTG17: sel = pattern_trigger_unit[1];
			default: sel = 1'b0;
		endcase
		raw_sync = sel ^ s.sec_ctl[B_INV];
		sync_edge = raw_sync && !s.sync_prev;
		n.sync_prev = raw_sync;
		hi = s.pri_period - DUTY_EDGE;
		chop_lim = 10'(({3'h0, s.chop_div} + 10'h001) * 10'(CHOP_STEPS / 2)
			- 10'h001);

		// bus channels
		if (awvalid && s.awready) begin
			n.aw_held = 1'b1;
			n.aw_addr = awaddr;
		end
		if (wvalid && s.wready) begin
			n.w_held = 1'b1;
			n.wdata = wdata[15:0];
			n.wstrb = wstrb[1:0];
		end
		if (s.bvalid && bready) begin
			n.bvalid = 1'b0;
		end
		if (s.rvalid && rready) begin
			n.rvalid = 1'b0;
		end

		// register writes; every access spoils a pending unlock
		if (wr) begin
			n.aw_held = 1'b0;
			n.w_held = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = old[16] ? RESP_OKAY : RESP_SLVERR;
			n.key = key_idle;
			case (s.aw_addr)
				A_PRI_CTL: n.module_enable = wv[B_MOD_EN];
				A_PRI_DIV: n.pri_div = wv[2:0];
				A_PRI_PER: n.pri_period = wv;
				A_PRI_CMP: n.pri_cmp = wv[15:CMP_LSB];
				A_SEC_CTL: begin
					n.sec_ctl[B_EIE:0] = wv[B_EIE:0];
					if (!wv[B_EIE]) begin
						n.sec_ctl[B_EPEND] = 1'b0;
					end
				end
				A_SEC_DIV: n.sec_div = wv[2:0];
				A_SEC_PER: n.sec_period = wv;
				A_SEC_CMP: n.sec_cmp = wv[15:CMP_LSB];
				A_CHOP: begin
					n.chop_en = wv[CHOP_EN];
					n.chop_div = wv[CHOP_LSB+:7];
				end
				A_DUTY: n.duty = wv;
				A_KEY: begin
					if (wv == KEY_ONE) begin
						n.key = key_half;
					end else if (s.key == key_half && wv == KEY_TWO) begin
						n.key = key_open;
					end
				end
				// one protected write consumes the unlock
				A_OUT_CTL, A_FLT_CTL: begin
					if (s.key != key_open) begin
						n.bresp = RESP_SLVERR;
					end else if (s.aw_addr == A_OUT_CTL) begin
						n.out_ctl = wv;
					end else begin
						n.flt_ctl = wv;
					end
				end
				default: begin
					for (int i = 0; i < NGEN; i++) begin
						if (s.aw_addr == A_GEN + ADDR_W'(4 * i)) begin
							n.gen[i][4:0] = wv[GEN_LSB+:5];
							if (!wv[GEN_LSB + 4]) begin
								n.gen[i].fault_pending = 1'b0;
							end
							if (!wv[GEN_LSB + 3]) begin
								n.gen[i].current_limit_pending = 1'b0;
							end
							if (!wv[GEN_LSB + 2]) begin
								n.gen[i].trigger_pending = 1'b0;
							end
						end
					end
				end
			endcase
		end

		// reads; a read is an access too
		if (rd) begin
			n.rvalid = 1'b1;
			n.rdata = {16'h0000, rv[15:0]};
			n.rresp = rv[16] ? RESP_OKAY : RESP_SLVERR;
			n.key = key_idle;
		end

		// secondary time base
		if (s.module_enable && sec_tick) begin
			// match only lands on multiples of eight counts
			n.match = (s.sec_cnt == {s.sec_cmp, 3'h0});
			if (s.sec_cnt >= s.sec_active) begin
				n.sec_cnt = 16'h0000;
				n.wrap = 1'b1;
				n.sec_active = s.sec_period;
			end else begin
				n.sec_cnt = s.sec_cnt + 16'h0001;
			end
		end
		if (s.module_enable && s.sec_ctl[B_XSYNC] && sync_edge) begin
			n.sec_cnt = 16'h0000;
		end
		if (s.sec_ctl[B_IMM]) begin
			n.sec_active = n.sec_period;
		end
		n.sync_out = n.wrap ^ n.sec_ctl[B_INV];
		n.sync_oe_b = !n.sec_ctl[B_SOE];
		// set wins over the enable-clear
		if (fire) begin
			n.sec_ctl[B_EPEND] = 1'b1;
		end
		n.irq = n.sec_ctl[B_EPEND] && n.sec_ctl[B_EIE];

		// chopper on the primary prescaler
		if (!(s.module_enable && s.chop_en)) begin
			n.chop_cnt = 10'h000;
			n.chop_out = 1'b0;
		end else if (pri_tick) begin
			if (s.chop_cnt >= chop_lim) begin
				n.chop_cnt = 10'h000;
				n.chop_out = !s.chop_out;
			end else begin
				n.chop_cnt = s.chop_cnt + 10'h001;
			end
		end

		// shared duty; edge resolution loss is left to the output stage
		if (s.duty < DUTY_EDGE) begin
			n.duty_out = DUTY_EDGE;
		end else if (s.duty > hi) begin
			n.duty_out = hi;
		end else begin
			n.duty_out = s.duty;
		end

		// generator status, events after writes so set wins
		for (int i = 0; i < NGEN; i++) begin
			if (fault_event[i]) begin
				n.gen[i].fault_pending = 1'b1;
			end
			if (current_limit_event[i]) begin
				n.gen[i].current_limit_pending = 1'b1;
			end
			if (trigger_event[i]) begin
				n.gen[i].trigger_pending = 1'b1;
			end
			n.gen_irq[i] = |(n.gen[i][7:5] & n.gen[i][4:2]);
		end

		n.awready = !n.aw_held && !n.bvalid;
		n.wready = !n.w_held && !n.bvalid;
		n.arready = !n.rvalid;
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			s <= '0;
			s.pri_period <= PERIOD_RST;
			s.sec_period <= PERIOD_RST;
			s.sec_active <= PERIOD_RST;
			s.sync_oe_b <= 1'b1;
			s.awready <= 1'b1;
			s.wready <= 1'b1;
			s.arready <= 1'b1;
		end else begin
			s <= n;
		end
	end

	// ==========================================================
	// outputs
	assign awready = s.awready;
	assign wready = s.wready;
	assign bvalid = s.bvalid;
	assign bresp = s.bresp;
	assign arready = s.arready;
	assign rvalid = s.rvalid;
	assign rdata = s.rdata;
	assign rresp = s.rresp;
	assign secondary_sync_output = s.sync_out;
	assign secondary_sync_output_oe_b = s.sync_oe_b;
	assign secondary_event_trigger = fire;
	assign secondary_event_irq = s.irq;
	assign secondary_master_counter = s.sec_cnt;
	assign chop_clock = s.chop_out;
	assign shared_duty = s.duty_out;
	assign generator_irq = s.gen_irq;
	for (genvar g = 0; g < NGEN; g++) begin : g_sel
		assign own_period_select[g] = s.gen[g].own_period_select;
		assign shared_duty_select[g] = s.gen[g].shared_duty_select;
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	sequence sync_hit_s;
		s.module_enable && s.sec_ctl[B_XSYNC] && sync_edge;
	endsequence

	match_align_a: assert property (s.match |->
		$past(s.sec_cnt[2:0]) == 3'h0) else $error("match off grid");
	match_value_a: assert property (s.match |->
		$past(s.sec_cnt) == {$past(s.sec_cmp), 3'h0})
		else $error("match at wrong count");
	pend_set_a: assert property (fire |=>
		s.sec_ctl[B_EPEND])
		else $error("event not pending");
	irq_gate_a: assert property (!s.sec_ctl[B_EIE] |->
		!secondary_event_irq) else $error("irq while disabled");
	imm_load_a: assert property ($changed(s.sec_period) &&
		s.sec_ctl[B_IMM] |-> s.sec_active == s.sec_period)
		else $error("immediate period not loaded");
	sync_pol_a: assert property (!s.wrap |->
		secondary_sync_output == s.sec_ctl[B_INV])
		else $error("idle sync level wrong");
	sync_oe_a: assert property (!s.sec_ctl[B_SOE] |->
		secondary_sync_output_oe_b) else $error("sync driven disabled");
	ext_sync_a: assert property (sync_hit_s |=>
		s.sec_cnt == 16'h0000) else $error("sync did not reset");
	chop_off_a: assert property (!s.chop_en |=>
		!chop_clock) else $error("chop runs disabled");
	chop_step_a: assert property (s.chop_en && $past(s.chop_en) &&
		$changed(s.chop_cnt) |-> $past(pri_tick) || s.chop_cnt == 10'h000)
		else $error("chop stepped without tick");
	duty_clamp_a: assert property (s.pri_period >= 16'h0010 &&
		$stable(s.pri_period) && $stable(s.duty) |=>
		shared_duty >= DUTY_EDGE &&
		shared_duty <= $past(s.pri_period) - DUTY_EDGE)
		else $error("shared duty out of range");
	unlock_only_a: assert property ($changed(s.out_ctl) ||
		$changed(s.flt_ctl) |-> $past(s.key) == key_open)
		else $error("protected write while locked");
	halt_a: assert property (!s.module_enable |=>
		s.sec_cnt == $past(s.sec_cnt)) else $error("counter ran disabled");
	for (genvar g = 0; g < NGEN; g++) begin : g_chk
		flt_clear_a: assert property (wr && !wv[GEN_LSB + 4] &&
			s.aw_addr == A_GEN + ADDR_W'(4 * g) && !fault_event[g] |=>
			!s.gen[g].fault_pending) else $error("fault pending stuck");
		trg_gate_a: assert property (!s.gen[g].trigger_irq_enable &&
			!s.gen[g].fault_irq_enable && !s.gen[g].current_limit_irq_enable
			|-> !generator_irq[g]) else $error("gen irq while disabled");
	end
endmodule

// file: testbench.sv
// self-checking bench for the pwm secondary time base block
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import pwm_regs_pkg::*;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0, inv = 1'b0, chop_d = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic awready, wready, bvalid, arready, rvalid;
	logic sin1, sin2, sout, soe_b, trig, eirq, chop;
	logic [1:0] bresp, rresp, ptu, r, flt, cl, tev, girq, own, shd;
	logic [31:0] rdata, d;
	logic [15:0] cnt, duty;
	logic [3:0] pss [3] = '{4'h0, 4'h2, 4'hf};
	int err_total = 0, comparisons = 0, cyc = 0;
	int nsync = 0, ntrig = 0, nchop = 0, tog = 0, ptog = 0;
	int t0, t1, s;

	pwm_time_base #(.NGEN(2)) pwm_time_base_inst (.clk(clk), .rst_b(rst_b),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr),
		.wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
		.bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
		.sync_input_one(sin1), .sync_input_two(sin2),
		.pattern_trigger_unit(ptu), .fault_event(flt),
		.current_limit_event(cl), .trigger_event(tev),
		.secondary_sync_output(sout), .secondary_sync_output_oe_b(soe_b),
		.secondary_event_trigger(trig), .secondary_event_irq(eirq),
		.secondary_master_counter(cnt), .chop_clock(chop),
		.shared_duty(duty), .generator_irq(girq),
		.own_period_select(own), .shared_duty_select(shd));

	pwm_far_side #(.NGEN(2)) pwm_far_side_inst (.clk(clk), .idle_high(inv),
		.sync_input_one(sin1), .sync_input_two(sin2),
		.pattern_trigger_unit(ptu), .fault_event(flt),
		.current_limit_event(cl), .trigger_event(tev));

	// ==========================================================
	// clock, monitors, timeout
	always #2 clk = ~clk;

	// sampled on the falling edge so counts never race the test process
	always @(negedge clk) begin
		cyc++;
		if (sout !== inv) nsync++;
		if (trig === 1'b1) ntrig++;
		if (chop !== chop_d) begin
			nchop++;
			ptog = tog;
			tog = cyc;
		end
		chop_d = chop;
		if (cyc > 60000) begin
			err_total++;
			end_of_test();
		end
	end

	// ==========================================================
	// tasks
	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] v);
		@(posedge clk);
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= {16'h0, v};
		wstrb <= 4'h3;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	task automatic wc(input logic [7:0] a, input logic [15:0] v,
		input logic [1:0] er = RESP_OKAY);
		wr(a, v);
		chk({30'h0, r}, {30'h0, er});
	endtask

	task automatic rc(input logic [7:0] a, input logic [15:0] e,
		input logic [1:0] er = RESP_OKAY);
		rd(a);
		chk(d, {16'h0, e});
		chk({30'h0, r}, {30'h0, er});
	endtask

	task automatic en(input logic v);
		wc(A_PRI_CTL, {v, 15'h0});
	endtask

	task automatic wait_sync(output int t);
		int k;
		k = nsync;
		while (nsync == k) @(posedge clk);
		t = cyc;
	endtask

	task automatic wait_trig();
		int k;
		k = ntrig;
		while (ntrig == k) @(posedge clk);
	endtask

	function automatic logic [15:0] ctl(input logic eie, iv, soe, xs,
		input logic [2:0] src, input logic [3:0] ps);
		return {4'h0, eie, 1'b0, iv, soe, xs, src, ps};
	endfunction

	// ==========================================================
	// main sequence
	initial begin
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		rc(A_SEC_PER, 16'hffff);
		rc(A_SEC_CMP, 16'h0000);
		rc(A_SEC_DIV, 16'h0000);
		rc(A_SEC_CTL, 16'h0000);
		wc(A_SEC_CMP, 16'hffff);
		rc(A_SEC_CMP, 16'hfff8);
		wc(A_SEC_DIV, 16'hffff);
		rc(A_SEC_DIV, 16'h0007);
		rc(8'h3c, 16'h0000, RESP_SLVERR);
		// unlock, then one protected write only
		wc(A_KEY, KEY_ONE);
		wc(A_KEY, KEY_TWO);
		wc(A_OUT_CTL, 16'h1234);
		wc(A_OUT_CTL, 16'h0005, RESP_SLVERR);
		rc(A_OUT_CTL, 16'h1234);
		wc(A_KEY, KEY_ONE);
		wc(A_KEY, KEY_TWO);
		rc(A_PRI_DIV, 16'h0000);
		wc(A_FLT_CTL, 16'h0007, RESP_SLVERR);
		rc(A_FLT_CTL, 16'h0000);
		// shortest legal period, low bits clear
		// immediate load, else the reset period defers it for 65536 counts
		wc(A_SEC_CTL, 16'h0400);
		wc(A_SEC_PER, 16'h0010);
		wc(A_SEC_CMP, 16'h0008);
		wc(A_SEC_CTL, ctl(0, 0, 1, 0, 3'h0, 4'h0));
		repeat (2) @(posedge clk);
		chk({31'h0, soe_b}, 32'h0);
		for (int c = 0; c < 7; c++) begin
			en(1'b0);
			wc(A_SEC_DIV, 16'(c));
			en(1'b1);
			wait_sync(t0);
			wait_sync(t1);
			chk(t1 - t0, (16'h0010 + 1) << c);
		end
		en(1'b0);
		wc(A_SEC_DIV, 16'h0000);
		foreach (pss[i]) begin
			en(1'b0);
			wc(A_SEC_CTL, ctl(0, 0, 1, 0, 3'h0, pss[i]));
			en(1'b1);
			wait_trig();
			s = nsync;
			wait_trig();
			chk(nsync - s, pss[i] + 1);
		end
		chk({31'h0, eirq}, 32'h0);
		rc(A_SEC_CTL, ctl(0, 0, 1, 0, 3'h0, 4'hf) | 16'h1000);
		wc(A_SEC_CTL, ctl(1, 0, 1, 0, 3'h0, 4'hf));
		repeat (2) @(posedge clk);
		chk({31'h0, eirq}, 32'h1);
		en(1'b0);
		wc(A_SEC_CTL, ctl(0, 0, 0, 0, 3'h0, 4'hf));
		rc(A_SEC_CTL, ctl(0, 0, 0, 0, 3'h0, 4'hf));
		chk({31'h0, eirq, soe_b}, 32'h1);
		// sources 0-3, reserved 4, sync off, then inverted source 0
		wc(A_SEC_PER, 16'hfff8);
		for (int i = 0; i < 7; i++) begin
			en(1'b0);
			inv <= (i == 6);
			wc(A_SEC_CTL, ctl(0, i == 6, 1, i != 5, 3'((i < 5) ? i : 0), 4'h0));
			repeat (3) @(posedge clk);
			chk({31'h0, sout}, {31'h0, inv});
			en(1'b1);
			repeat (60) @(posedge clk);
			pwm_far_side_inst.pulse_sync((i < 5) ? i : 0);
			repeat (3) @(posedge clk);
			chk({31'h0, cnt < 16'h0010}, {31'h0, i < 4 || i == 6});
		end
		inv <= 1'b0;
		wc(A_GEN, 16'h1f00);
		pwm_far_side_inst.pulse_gen(0);
		repeat (2) @(posedge clk);
		chk({28'h0, own, shd}, 32'h5);
		chk({30'h0, girq}, 32'h1);
		rc(A_GEN, 16'hff00);
		wc(A_GEN, 16'h0300);
		rc(A_GEN, 16'h0300);
		chk({30'h0, girq}, 32'h0);
		// chop follows the primary divider, not the secondary one
		en(1'b0);
		wc(A_SEC_DIV, 16'h0003);
		wc(A_CHOP, 16'h8008);
		for (int c = 0; c < 2; c++) begin
			en(1'b0);
			wc(A_PRI_DIV, 16'(c));
			en(1'b1);
			repeat (200) @(posedge clk);
			chk(tog - ptog, 16 << c);
		end
		wc(A_CHOP, 16'h0000);
		repeat (4) @(posedge clk);
		s = nchop;
		repeat (100) @(posedge clk);
		chk(nchop - s, 0);
		wc(A_PRI_PER, 16'h0100);
		wc(A_DUTY, 16'h0002);
		repeat (3) @(posedge clk);
		chk({16'h0, duty}, 32'h0008);
		wc(A_DUTY, 16'h00fe);
		repeat (3) @(posedge clk);
		chk({16'h0, duty}, 32'h00f8);
		wc(A_DUTY, 16'h0080);
		repeat (3) @(posedge clk);
		chk({16'h0, duty}, 32'h0080);
		end_of_test();
	end
endmodule
